// >>> dv/dofc_top_props.sv
// assertions on the register port and sample outputs of the format block
`timescale 1ns/1ps
module dofc_top_props
	import dofc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [8:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic out_valid,
	input wire logic [47:0] chan_a_phases,
	input wire logic [47:0] chan_b_phases,
	input wire logic chan_a_current_on,
	input wire logic chan_b_current_on,
	input wire logic [5:0] chan_a_fine_current,
	input wire logic [5:0] chan_b_fine_current,
	input wire logic [3:0] chan_a_coarse_current,
	input wire logic [3:0] chan_b_coarse_current,
	input wire logic datapath_enable,
	input wire logic clock_doubling_enable
);
	// one clock domain, so clock and reset are given once
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	a_coarse_readback: assert property (reg_wr && reg_addr == DOFC_OFS_COARSE ##1 reg_rd
		&& reg_addr == DOFC_OFS_COARSE |=> reg_rdata == $past(reg_wdata, 2))
		else $error("coarse read back differs");
	a_coarse_out: assert property (reg_wr && reg_addr == DOFC_OFS_COARSE ##1
		!(reg_wr && reg_addr == DOFC_OFS_COARSE)
		|=> {chan_b_coarse_current, chan_a_coarse_current} == $past(reg_wdata, 2))
		else $error("coarse outputs differ");
	a_channel_a_current_out: assert property (reg_wr && reg_addr == DOFC_OFS_CHANNEL_A_CURRENT ##1
		!(reg_wr && reg_addr == DOFC_OFS_CHANNEL_A_CURRENT)
		|=> {chan_a_current_on, 1'b0, chan_a_fine_current} == ($past(reg_wdata, 2) & 8'hbf))
		else $error("channel a current outputs differ");
	a_reset_current: assert property ($rose(rst_n) |-> chan_a_current_on && chan_b_current_on
		&& chan_a_fine_current == 6'h1f && chan_b_fine_current == 6'h1f)
		else $error("current reset values wrong");
	a_reset_config: assert property ($rose(rst_n) |-> !datapath_enable && !clock_doubling_enable
		&& chan_a_coarse_current == 4'h0 && chan_b_coarse_current == 4'h0)
		else $error("config reset values wrong");
	a_valid_cause: assert property (out_valid |-> $past(sample_valid))
		else $error("output valid without sample");
	a_phases_off: assert property (!datapath_enable && !$past(datapath_enable)
		|-> chan_a_phases == 48'h0 && chan_b_phases == 48'h0)
		else $error("phases not cleared while disabled");
	a_phase_shape: assert property (out_valid |-> chan_a_phases[11:0] == chan_a_phases[23:12]
		|| (chan_a_phases[11:0] == 12'h0 && chan_a_phases[47:36] == 12'h0))
		else $error("phase pairing broken");
endmodule

bind dofc_top dofc_top_props u_props (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .sample_valid, .out_valid, .chan_a_phases, .chan_b_phases,
	.chan_a_current_on, .chan_b_current_on, .chan_a_fine_current, .chan_b_fine_current,
	.chan_a_coarse_current, .chan_b_coarse_current, .datapath_enable, .clock_doubling_enable);

// >>> dv/tb_dofc_top.sv
// self-checking bench for the output format configuration block
`timescale 1ns/1ps
module tb_dofc_top;
	import dofc_pkg::*;
	logic sys_clk, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, transmit_enable = 1'b0;
	logic sample_valid = 1'b0, out_valid, ea, eb, dpe, dce;
	logic [8:0] reg_addr = 9'h000;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
	logic [11:0] sa = 12'h000, sb = 12'h000, a, b;
	logic [47:0] pa, pb;
	logic [5:0] fa, fb;
	logic [3:0] ca, cb;
	logic [7:0] sh [6];
	logic [31:0] seed = 32'h26fea1f5;
	int fail_count = 0, samples_checked = 0, cyc = 0, k, dv;
	localparam logic [8:0] AD [6] = '{DOFC_OFS_PULSE, DOFC_OFS_COARSE, DOFC_OFS_CHANNEL_A_CURRENT,
		DOFC_OFS_CHANNEL_B_CURRENT, DOFC_OFS_DITHER, DOFC_OFS_CTRL};
	localparam logic [7:0] RV [6] = '{8'h00, 8'h00, 8'h9f, 8'h9f, 8'h00, 8'h00};
	localparam logic [7:0] MK [6] = '{8'h33, 8'hff, 8'hbf, 8'hbf, 8'h0f, 8'h07};

	dofc_top dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.transmit_enable, .sample_valid, .chan_a_sample(sa), .chan_b_sample(sb), .out_valid,
		.chan_a_phases(pa), .chan_b_phases(pb), .chan_a_current_on(ea), .chan_b_current_on(eb),
		.chan_a_fine_current(fa), .chan_b_fine_current(fb), .chan_a_coarse_current(ca),
		.chan_b_coarse_current(cb), .datapath_enable(dpe), .clock_doubling_enable(dce));

	// free-running 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	// saturating negate: the most negative code has no positive twin
	function automatic logic [11:0] neg(logic [11:0] s);
		return (s == 12'h800) ? 12'h7ff : -s;
	endfunction
	function automatic logic [47:0] shape(logic [1:0] f, logic [11:0] s);
		case (f)
			2'd0: return {s, s, s, s};
			2'd1: return {neg(s), neg(s), s, s};
			2'd2: return {24'h0, s, s};
			default: return {12'h0, neg(s), s, 12'h0};
		endcase
	endfunction

	task automatic report_and_stop();
		if (fail_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(string n, logic [47:0] e, logic [47:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [8:0] ad, logic [7:0] dt);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= dt;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(string n, logic [8:0] ad, logic [7:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk(n, e, reg_rdata);
	endtask
	// write then read back with no gap between the strobes
	task automatic wr_rd(string n, logic [8:0] ad, logic [7:0] dt, logic [7:0] e);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= dt;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk(n, e, reg_rdata);
	endtask
	// park the control register while a field changes, then run again
	task automatic setc(logic [8:0] ad, logic [7:0] dt, logic [7:0] hold);
		wr(DOFC_OFS_CTRL, hold);
		wr(ad, dt);
		wr(DOFC_OFS_CTRL, 8'h07);
	endtask
	task automatic samp(logic [11:0] x, logic [11:0] y);
		@(posedge sys_clk);
		sample_valid <= 1'b1;
		sa <= x;
		sb <= y;
		@(posedge sys_clk);
		sample_valid <= 1'b0;
		@(negedge sys_clk);
	endtask

	// hang guard, well above the few hundred cycles the run needs
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end

	initial begin
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) rd("reset value", AD[i], RV[i]);
		sh = RV;
		for (int i = 0; i < 40; i++) begin
			k = int'(rnd() % 5);
			d = 8'(rnd());
			sh[k] = d & MK[k];
			wr_rd("read back", AD[k], d, d & MK[k]);
			chk("levels", {sh[1], sh[2], sh[3]}, {cb, ca, ea, 1'b0, fa, eb, 1'b0, fb});
		end
		wr(9'h155, 8'hff);
		rd("unmapped", 9'h155, 8'h00);
		wr(DOFC_OFS_CHANNEL_A_CURRENT, 8'h9f);
		wr(DOFC_OFS_CHANNEL_B_CURRENT, 8'h9f);
		setc(DOFC_OFS_DITHER, 8'h00, 8'h03);
		@(negedge sys_clk);
		chk("enables", 48'h3, {dpe, dce});
		for (int f = 0; f < 4; f++) begin
			setc(DOFC_OFS_PULSE, {2'b0, f[1:0], 2'b0, f[1:0]}, 8'h00);
			for (int i = 0; i < 6; i++) begin
				a = (i == 0) ? 12'h800 : (i == 1) ? 12'h7ff : 12'(rnd());
				b = 12'(rnd());
				samp(a, b);
				chk("out valid", 48'h1, out_valid);
				chk("phases a", shape(f[1:0], a), pa);
				chk("phases b", shape(f[1:0], b), pb);
			end
		end
		wr(DOFC_OFS_CHANNEL_A_CURRENT, 8'h1f);
		samp(a, b);
		chk("current off a", 48'h0, pa);
		chk("current on b", shape(2'd3, b), pb);
		wr(DOFC_OFS_CHANNEL_A_CURRENT, 8'h9f);
		wr(DOFC_OFS_CTRL, 8'h03);
		transmit_enable <= 1'b1;
		samp(a, b);
		chk("pin transmit", shape(2'd3, a), pa);
		@(posedge sys_clk);
		transmit_enable <= 1'b0;
		samp(a, b);
		chk("transmit off", 48'h0, pa);
		wr(DOFC_OFS_CTRL, 8'h06);
		rd("status", DOFC_OFS_STATUS, 8'h02);
		chk("enables off", 48'h1, {dpe, dce});
		samp(a, b);
		chk("valid disabled", 48'h0, out_valid);
		chk("phases disabled", 48'h0, pa);
		setc(DOFC_OFS_PULSE, 8'h00, 8'h00);
		for (int c = 0; c < 4; c++) begin
			setc(DOFC_OFS_DITHER, {4'h0, c[1:0], c[1:0]}, 8'h03);
			for (int i = 0; i < 8; i++) begin
				samp(12'h100, 12'h100);
				dv = int'(signed'(pa[11:0])) - 256;
				chk("dither a", 48'h1, (c == 0) ? dv == 0 : dv >= -(1 << c) && dv < (1 << c));
				dv = int'(signed'(pb[11:0])) - 256;
				chk("dither b", 48'h1, (c == 0) ? dv == 0 : dv >= -(1 << c) && dv < (1 << c));
			end
		end
		report_and_stop();
	end
endmodule

// >>> hw/dofc_pkg.sv
// constants, field layouts and codes for the output format configuration block
package dofc_pkg;

	// register port, sample, phase and dither generator widths
	localparam int DOFC_ADDR_W = 9;
	localparam int DOFC_DATA_W = 8;
	localparam int DOFC_SAMPLE_W = 12;
	localparam int DOFC_PHASE_W = 4 * DOFC_SAMPLE_W;
	localparam int DOFC_LFSR_W = 16;

	// register offsets
	localparam logic [8:0] DOFC_OFS_DITHER = 9'h140;
	localparam logic [8:0] DOFC_OFS_PULSE = 9'h160;
	localparam logic [8:0] DOFC_OFS_COARSE = 9'h170;
	localparam logic [8:0] DOFC_OFS_CHANNEL_A_CURRENT = 9'h171;
	localparam logic [8:0] DOFC_OFS_CHANNEL_B_CURRENT = 9'h172;
	localparam logic [8:0] DOFC_OFS_CTRL = 9'h1f0;
	localparam logic [8:0] DOFC_OFS_STATUS = 9'h1f1;

	// field positions
	localparam int DOFC_DITH_A_LSB = 0;
	localparam int DOFC_DITH_B_LSB = 2;
	localparam int DOFC_FMT_A_LSB = 0;
	localparam int DOFC_FMT_B_LSB = 4;
	localparam int DOFC_COARSE_A_LSB = 0;
	localparam int DOFC_COARSE_B_LSB = 4;
	localparam int DOFC_CUR_EN_BIT = 7;
	localparam int DOFC_FINE_LSB = 0;
	localparam int DOFC_CTRL_DP_BIT = 0;
	localparam int DOFC_CTRL_DCM_BIT = 1;
	localparam int DOFC_CTRL_TX_BIT = 2;
	localparam int DOFC_ST_FAULT_BIT = 0;
	localparam int DOFC_ST_TX_BIT = 1;
	localparam int DOFC_ST_DP_BIT = 2;

	// writable bits; reserved bits are not stored and read as zero
	localparam logic [7:0] DOFC_DITHER_MASK = 8'h0f;
	localparam logic [7:0] DOFC_PULSE_MASK = 8'h33;
	localparam logic [7:0] DOFC_COARSE_MASK = 8'hff;
	localparam logic [7:0] DOFC_CUR_MASK = 8'hbf;
	localparam logic [7:0] DOFC_CTRL_MASK = 8'h07;

	// reset values
	localparam logic [7:0] DOFC_DITHER_RST = 8'h00;
	localparam logic [7:0] DOFC_PULSE_RST = 8'h00;
	localparam logic [7:0] DOFC_COARSE_RST = 8'h00;
	localparam logic [7:0] DOFC_CUR_RST = 8'h9f;
	localparam logic [7:0] DOFC_CTRL_RST = 8'h00;

	// sample limits and dither generator
	localparam logic [11:0] DOFC_SAMPLE_MAX = 12'h7ff;
	localparam logic [11:0] DOFC_SAMPLE_MIN = 12'h800;
	localparam logic [11:0] DOFC_SAMPLE_ZERO = 12'h000;
	localparam logic [15:0] DOFC_LFSR_SEED = 16'hace1;
	localparam logic [15:0] DOFC_LFSR_TAPS = 16'hb400;
	localparam int DOFC_LFSR_A_LSB = 0;
	localparam int DOFC_LFSR_B_LSB = 8;
	localparam logic [7:0] DOFC_RDATA_IDLE = 8'h00;

	typedef enum logic [1:0] {
		DOFC_FMT_NRZ = 2'b00,
		DOFC_FMT_RTI = 2'b01,
		DOFC_FMT_RTZ = 2'b10,
		DOFC_FMT_QUAD = 2'b11
	} dofc_format_e;

	typedef enum logic [1:0] {
		DOFC_DITH_OFF = 2'b00,
		DOFC_DITH_R1 = 2'b01,
		DOFC_DITH_R3 = 2'b10,
		DOFC_DITH_R7 = 2'b11
	} dofc_dither_e;

endpackage

// >>> hw/dofc_top.sv
// output format configuration registers and per-channel sample shaping
//
// Overview of operation
// - dither code 0 none, 1 +1/-2, 2 +3/-4, 3 +7/-8 lsb
// - pulse format register: channel b bits 5-4, channel a bits 1-0
// - format 0 non-return-to-zero, 1 return-to-inverse, 2 return-to-zero
// - format 3 gives zero, sample, inverse, zero; needs clock doubling on
// - coarse register: channel b bits 7-4, channel a bits 3-0, reset zero
// - channel a current bit 7 enables output current, resets to one
// - channel a fine code in bits 5-0 resets 1f; bit 6 reserved zero
// - channel b current register resets to 9f with same layout
// - datapath held in reset while datapath enable is clear
//
// register map, byte addresses, reserved bits not stored and read as zero
// 0x140 dither_select: channel a bits 1-0, channel b bits 3-2
// 0x160 pulse_format_select: channel a bits 1-0, channel b bits 5-4
// 0x170 coarse_current_codes: channel a bits 3-0, channel b bits 7-4
// 0x171 channel_a_current: bit 7 current on, bits 5-0 fine code
// 0x172 channel_b_current: bit 7 current on, bits 5-0 fine code
// 0x1f0 control: bit 0 datapath, bit 1 clock doubling, bit 2 transmit
// 0x1f1 status, live and read only: bit 0 bad format mix, bit 1 transmit, bit 2 datapath
`timescale 1ns/1ps

module dofc_top (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [dofc_pkg::DOFC_ADDR_W-1:0] reg_addr,
	input wire logic [dofc_pkg::DOFC_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [dofc_pkg::DOFC_DATA_W-1:0] reg_rdata,
	input wire logic transmit_enable,
	input wire logic sample_valid,
	input wire logic [dofc_pkg::DOFC_SAMPLE_W-1:0] chan_a_sample,
	input wire logic [dofc_pkg::DOFC_SAMPLE_W-1:0] chan_b_sample,
	output logic out_valid,
	output logic [dofc_pkg::DOFC_PHASE_W-1:0] chan_a_phases,
	output logic [dofc_pkg::DOFC_PHASE_W-1:0] chan_b_phases,
	output logic chan_a_current_on,
	output logic chan_b_current_on,
	output logic [5:0] chan_a_fine_current,
	output logic [5:0] chan_b_fine_current,
	output logic [3:0] chan_a_coarse_current,
	output logic [3:0] chan_b_coarse_current,
	output logic datapath_enable,
	output logic clock_doubling_enable
);
	import dofc_pkg::*;

	// saturating add of a five-bit signed dither to a signed sample
	function automatic logic [11:0] sat_add(input logic [11:0] s, input logic [4:0] d);
		logic [12:0] sum;
		sum = {s[11], s} + {{8{d[4]}}, d};
		// sign bits differ only on overflow
		if (sum[12] != sum[11]) begin
			sat_add = sum[12] ? DOFC_SAMPLE_MIN : DOFC_SAMPLE_MAX;
		end else begin
			sat_add = sum[11:0];
		end
	endfunction

	// negation clipped at full scale, the most negative code has no mirror
	function automatic logic [11:0] sat_neg(input logic [11:0] s);
		if (s == DOFC_SAMPLE_MIN) begin
			sat_neg = DOFC_SAMPLE_MAX;
		end else begin
			sat_neg = ~s + 12'h001;
		end
	endfunction

	// map a dither code and four random bits onto a uniform signed offset
	function automatic logic [4:0] dither_value(input dofc_dither_e code, input logic [3:0] rnd);
		unique case (code)
			DOFC_DITH_OFF: begin
				dither_value = 5'h00;
			end
			DOFC_DITH_R1: begin
				dither_value = {{3{rnd[1]}}, rnd[1:0]};
			end
			DOFC_DITH_R3: begin
				dither_value = {{2{rnd[2]}}, rnd[2:0]};
			end
			DOFC_DITH_R7: begin
				dither_value = {rnd[3], rnd[3:0]};
			end
		endcase
	endfunction

	// one step of the dither generator: shift left, parity of the tapped bits back in
	function automatic logic [15:0] lfsr_step(input logic [15:0] r);
		lfsr_step = {r[14:0], ^(r & DOFC_LFSR_TAPS)};
	endfunction

	// four sub-sample phases, phase 0 in the low bits
	function automatic logic [47:0] shape(input dofc_format_e fmt, input logic dbl,
			input logic [11:0] s);
		logic [11:0] inv;
		inv = sat_neg(s);
		unique case (fmt)
			DOFC_FMT_NRZ: begin
				shape = {s, s, s, s};
			end
			DOFC_FMT_RTI: begin
				shape = {inv, inv, s, s};
			end
			DOFC_FMT_RTZ: begin
				shape = {DOFC_SAMPLE_ZERO, DOFC_SAMPLE_ZERO, s, s};
			end
			DOFC_FMT_QUAD: begin
				if (dbl) begin
					shape = {DOFC_SAMPLE_ZERO, inv, s, DOFC_SAMPLE_ZERO};
				end else begin
					// undefined setting, so drive nothing rather than guess
					shape = {DOFC_SAMPLE_ZERO, DOFC_SAMPLE_ZERO, DOFC_SAMPLE_ZERO,
						DOFC_SAMPLE_ZERO};
				end
			end
		endcase
	endfunction

	// one channel: dither, shape, then gate; a gated channel shows zero
	function automatic logic [47:0] channel_out(input logic gate, input dofc_format_e fmt,
			input logic dbl, input dofc_dither_e code, input logic [3:0] rnd,
			input logic [11:0] s);
		if (gate) begin
			channel_out = shape(fmt, dbl, sat_add(s, dither_value(code, rnd)));
		end else begin
			// current off or transmit low: output idles at code zero
			channel_out = '0;
		end
	endfunction

	// configuration registers
	logic [7:0] dither_select;
	logic [7:0] pulse_format_select;
	logic [7:0] coarse_current_codes;
	logic [7:0] channel_a_current;
	logic [7:0] channel_b_current;
	logic [7:0] control;
	logic [7:0] next_dither_select;
	logic [7:0] next_pulse_format_select;
	logic [7:0] next_coarse_current_codes;
	logic [7:0] next_channel_a_current;
	logic [7:0] next_channel_b_current;
	logic [7:0] next_control;
	logic [7:0] next_reg_rdata;

	// datapath state
	logic [15:0] lfsr;
	logic [15:0] next_lfsr;
	logic next_out_valid;
	logic [47:0] next_chan_a_phases;
	logic [47:0] next_chan_b_phases;

	// decoded views of the fields
	logic dp_on;
	logic dbl_on;
	logic tx_on;
	logic fault;
	dofc_format_e fmt_a;
	dofc_format_e fmt_b;
	dofc_dither_e dith_a;
	dofc_dither_e dith_b;

	assign dp_on = control[DOFC_CTRL_DP_BIT];
	assign dbl_on = control[DOFC_CTRL_DCM_BIT];
	// pin or register may enable transmission
	assign tx_on = transmit_enable | control[DOFC_CTRL_TX_BIT];
	assign fmt_a = dofc_format_e'(pulse_format_select[DOFC_FMT_A_LSB +: 2]);
	assign fmt_b = dofc_format_e'(pulse_format_select[DOFC_FMT_B_LSB +: 2]);
	assign dith_a = dofc_dither_e'(dither_select[DOFC_DITH_A_LSB +: 2]);
	assign dith_b = dofc_dither_e'(dither_select[DOFC_DITH_B_LSB +: 2]);
	// reported only; the outcome is undefined, so shaping emits zeros
	assign fault = tx_on & ~dbl_on & ((fmt_a == DOFC_FMT_QUAD) | (fmt_b == DOFC_FMT_QUAD));

	// register writes; format and dither are not guarded, software owns timing
	always_comb begin
		next_dither_select = dither_select;
		next_pulse_format_select = pulse_format_select;
		next_coarse_current_codes = coarse_current_codes;
		next_channel_a_current = channel_a_current;
		next_channel_b_current = channel_b_current;
		next_control = control;
		if (reg_wr) begin
			unique case (reg_addr)
				DOFC_OFS_DITHER: begin
					next_dither_select = reg_wdata & DOFC_DITHER_MASK;
				end
				DOFC_OFS_PULSE: begin
					next_pulse_format_select = reg_wdata & DOFC_PULSE_MASK;
				end
				DOFC_OFS_COARSE: begin
					next_coarse_current_codes = reg_wdata & DOFC_COARSE_MASK;
				end
				DOFC_OFS_CHANNEL_A_CURRENT: begin
					next_channel_a_current = reg_wdata & DOFC_CUR_MASK;
				end
				DOFC_OFS_CHANNEL_B_CURRENT: begin
					next_channel_b_current = reg_wdata & DOFC_CUR_MASK;
				end
				// own control bits: datapath, doubling, transmit
				DOFC_OFS_CTRL: begin
					next_control = reg_wdata & DOFC_CTRL_MASK;
				end
				// unmapped addresses and the read-only status fall away
				default: begin
				end
			endcase
		end
	end

	// read data stands for exactly the cycle after the strobe
	always_comb begin
		next_reg_rdata = DOFC_RDATA_IDLE;
		if (reg_rd) begin
			// same decode as writes plus the status register; unmapped reads give zero
			unique case (reg_addr)
				DOFC_OFS_DITHER: begin
					next_reg_rdata = dither_select;
				end
				DOFC_OFS_PULSE: begin
					next_reg_rdata = pulse_format_select;
				end
				DOFC_OFS_COARSE: begin
					next_reg_rdata = coarse_current_codes;
				end
				DOFC_OFS_CHANNEL_A_CURRENT: begin
					next_reg_rdata = channel_a_current;
				end
				DOFC_OFS_CHANNEL_B_CURRENT: begin
					next_reg_rdata = channel_b_current;
				end
				DOFC_OFS_CTRL: begin
					next_reg_rdata = control;
				end
				// status is live; nothing sticky to clear
				DOFC_OFS_STATUS: begin
					next_reg_rdata[DOFC_ST_FAULT_BIT] = fault;
					next_reg_rdata[DOFC_ST_TX_BIT] = tx_on;
					next_reg_rdata[DOFC_ST_DP_BIT] = dp_on;
				end
				default: begin
					next_reg_rdata = DOFC_RDATA_IDLE;
				end
			endcase
		end
	end

	// register file flops
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dither_select <= DOFC_DITHER_RST;
			pulse_format_select <= DOFC_PULSE_RST;
			coarse_current_codes <= DOFC_COARSE_RST;
			channel_a_current <= DOFC_CUR_RST;
			channel_b_current <= DOFC_CUR_RST;
			control <= DOFC_CTRL_RST;
			// idle read data is zero, never the last value read
			reg_rdata <= DOFC_RDATA_IDLE;
		end else begin
			dither_select <= next_dither_select;
			pulse_format_select <= next_pulse_format_select;
			coarse_current_codes <= next_coarse_current_codes;
			channel_a_current <= next_channel_a_current;
			channel_b_current <= next_channel_b_current;
			control <= next_control;
			reg_rdata <= next_reg_rdata;
		end
	end

	// analogue settings leave straight from the register flops
	// current enable bits, fine and coarse codes, datapath and doubling enables
	assign chan_a_current_on = channel_a_current[DOFC_CUR_EN_BIT];
	assign chan_b_current_on = channel_b_current[DOFC_CUR_EN_BIT];
	assign chan_a_fine_current = channel_a_current[DOFC_FINE_LSB +: 6];
	assign chan_b_fine_current = channel_b_current[DOFC_FINE_LSB +: 6];
	assign chan_a_coarse_current = coarse_current_codes[DOFC_COARSE_A_LSB +: 4];
	assign chan_b_coarse_current = coarse_current_codes[DOFC_COARSE_B_LSB +: 4];
	assign datapath_enable = control[DOFC_CTRL_DP_BIT];
	assign clock_doubling_enable = control[DOFC_CTRL_DCM_BIT];

	// sample path: dither, shape, gate by transmit and current enable
	always_comb begin
		next_lfsr = lfsr;
		next_out_valid = 1'b0;
		next_chan_a_phases = chan_a_phases;
		next_chan_b_phases = chan_b_phases;
		if (!dp_on) begin
			next_lfsr = DOFC_LFSR_SEED;
			next_chan_a_phases = '0;
			next_chan_b_phases = '0;
		end else if (sample_valid) begin
			next_lfsr = lfsr_step(lfsr);
			next_out_valid = 1'b1;
			// both channels draw from disjoint nibbles of the pre-step value
			next_chan_a_phases = channel_out(tx_on && chan_a_current_on, fmt_a,
				dbl_on, dith_a, lfsr[DOFC_LFSR_A_LSB +: 4], chan_a_sample);
			next_chan_b_phases = channel_out(tx_on && chan_b_current_on, fmt_b,
				dbl_on, dith_b, lfsr[DOFC_LFSR_B_LSB +: 4], chan_b_sample);
		end
	end

	// datapath flops
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			// seed on reset so a run repeats the same dither
			lfsr <= DOFC_LFSR_SEED;
			out_valid <= 1'b0;
			chan_a_phases <= '0;
			chan_b_phases <= '0;
		end else begin
			lfsr <= next_lfsr;
			out_valid <= next_out_valid;
			chan_a_phases <= next_chan_a_phases;
			chan_b_phases <= next_chan_b_phases;
		end
	end

endmodule
